// [dv/capture_buffer_status_flags_bench.sv]
// Self-checking bench for the capture buffer and status flag block.
`timescale 1ns/1ps
module capture_buffer_status_flags_bench;
  import cbs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic evt = 1'b0;
  logic ext = 1'b0;
  logic [6:0] tick = 7'h7F;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, r, c1;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #5 pclk = ~pclk;
  cbs_apb_host h(.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  cbs_top i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_input_pin(evt), .ext_count_clock(ext),
    .prescale_tick(tick), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    h.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  task automatic pin_pulse(input bit to_ext);
    @(posedge pclk);
    if (to_ext) ext <= 1'b1; else evt <= 1'b1;
    repeat (3) @(posedge pclk);
    if (to_ext) ext <= 1'b0; else evt <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pin_pulse
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_HISTORY); chk("history reset", 32'h0000_0000, r);
    rd(REG_STATUS); chk("status reset", 32'h0000_0000, r);
    rd(8'h1C); chk("unmapped error", 32'h0000_0001, {31'h0, e});
    wr(REG_LIMIT, 32'h0000_0005);
    wr(REG_CONTROL, 32'h0000_0004);
    wr(REG_COUNTER, 32'h0000_FFF0);
    repeat (30) @(posedge pclk);
    wr(REG_CONTROL, 32'h0000_0000);
    // Writing zero without a prior read of the set flags must not clear them.
    wr(REG_STATUS, 32'h0000_0000);
    rd(REG_STATUS); chk("wrap and match", 32'h0000_00A0, r);
    wr(REG_IRQ_MASK, 32'h0000_0080);
    repeat (2) @(posedge pclk); chk("irq on", 32'h1, {31'h0, irq});
    wr(REG_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk); chk("irq off", 32'h0, {31'h0, irq});
    wr(REG_STATUS, 32'h0000_0000);
    rd(REG_STATUS); chk("flags cleared", 32'h0000_0000, r);
    wr(REG_CONTROL, 32'h0000_0006);
    pin_pulse(1'b0);
    rd(REG_CAPTURE); c1 = r;
    pin_pulse(1'b0);
    rd(REG_HISTORY); chk("history keeps old", c1, r);
    rd(REG_STATUS); chk("capture flag", 32'h0000_0008, r & 32'h0000_0008);
    wr(REG_CONTROL, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_0000);
    wr(REG_LIMIT, 32'h0000_0003);
    wr(REG_CONTROL, 32'h0000_0007);
    pin_pulse(1'b0);
    repeat (14) @(posedge pclk);
    pin_pulse(1'b0);
    rd(REG_STATUS); chk("period too long", 32'h0000_0048, r & 32'h0000_00E8);
    rd(REG_CAPTURE); chk("period above limit", 32'h1, {31'h0, r > 32'h3});
    wr(REG_CONTROL, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_0010);
    wr(REG_CONTROL, 32'h0000_0074);
    @(posedge pclk) ext <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(REG_COUNTER); chk("rise counted", 32'h0000_0001, r);
    @(posedge pclk) ext <= 1'b0;
    repeat (3) pin_pulse(1'b1);
    rd(REG_COUNTER); chk("rising edges", 32'h0000_0004, r);
    wr(REG_STATUS, 32'h0000_0000);
    @(posedge pclk) ext <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(REG_COUNTER); chk("rise ignored", 32'h0000_0004, r);
    @(posedge pclk) ext <= 1'b0;
    repeat (2) pin_pulse(1'b1);
    rd(REG_COUNTER); chk("falling edges", 32'h0000_0007, r);
    tally_and_finish();
  end
endmodule : capture_buffer_status_flags_bench

// [dv/cbs_apb_host.sv]
// Bus master model standing in for the processor on the register bus.
`timescale 1ns/1ps
module cbs_apb_host
  import cbs_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end
  // The request is held until pready is seen at an edge, however late it comes.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : cbs_apb_host

// [dv/cbs_assertions.sv]
// Port-level checker for the capture buffer and status flag block.
`timescale 1ns/1ps
module cbs_assertions
  import cbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  ready_latency_a: assert property ((psel && !penable) |=> ##1 pready)
    else $error("pready missing two cycles after setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside the answer cycle");
  history_width_a: assert property (pready && !pwrite && paddr == REG_HISTORY
    |-> prdata[31:16] == 16'h0000) else $error("history upper half not zero");
  capture_width_a: assert property (pready && !pwrite && paddr == REG_CAPTURE
    |-> prdata[31:16] == 16'h0000) else $error("capture upper half not zero");
  status_bits_a: assert property (pready && !pwrite && paddr == REG_STATUS
    |-> prdata[31:8] == 24'h00_0000 && prdata[2:0] == 3'h0)
    else $error("unused status bits read as one");
  unmapped_err_a: assert property (pready && !pwrite && paddr > REG_IRQ_MASK
    |-> pslverr && prdata == ERR_DATA) else $error("unmapped read not refused");
  irq_masked_a: assert property (pready && pwrite && paddr == REG_IRQ_MASK
    && pwdata == 32'h0000_0000 && !pslverr |=> ##1 !irq)
    else $error("irq high with all sources masked");
  cover property (pready && pslverr);
  cover property (irq);
  cover property (pready && !pwrite && paddr == REG_HISTORY);
endmodule : cbs_assertions

bind cbs_top cbs_assertions u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// [rtl/cbs_pkg.sv]
// Package for the capture buffer and status flag block.
package cbs_pkg;

  localparam logic [7:0] REG_COUNTER = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_CAPTURE = 8'h08;
  localparam logic [7:0] REG_HISTORY = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CONTROL = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  localparam int BIT_WRAP = 7;
  localparam int BIT_TOO_LONG = 6;
  localparam int BIT_MATCH = 5;
  localparam int BIT_EDGE_SEL = 4;
  localparam int BIT_CAPTURE = 3;

  localparam int CTL_MODE = 0;
  localparam int CTL_CAP_EDGE = 1;
  localparam int CTL_RUN = 2;
  localparam int CTL_CLK_LSB = 4;

  localparam logic [2:0] CLK_EXTERNAL = 3'h7;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] HISTORY_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FLAG_MASK = 8'hE8;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [31:0] ERR_DATA = 32'hDEAD_BEEF;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } cbs_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } cbs_rsp_s;

  typedef enum logic [1:0] {
    CBS_WAIT_FIRST,
    CBS_MEASURE
  } cbs_meas_e;

endpackage : cbs_pkg

// [rtl/cbs_top.sv]
// Capture buffer, status flags and period timer channel behind an APB slave.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module cbs_top
  import cbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_input_pin,
  input wire logic ext_count_clock,
  input wire logic [6:0] prescale_tick,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  cbs_req_s req;
  logic access;
  logic wr_en;
  logic rd_en;
  logic full_word;
  logic wr_full;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign access = psel && penable && pready;
  assign wr_en = access && req.write;
  assign rd_en = access && !req.write;
  // Narrow writes are refused so 16-bit registers are never half updated.
  assign full_word = (pstrb == 4'hF);
  assign wr_full = wr_en && full_word;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // A full-word write that lands on the given register.
  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] off);
    wr_hit = we && hit(a, off);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Registers and edge detection.

  logic [15:0] free_running_counter;
  logic [15:0] upper_limit_compare;
  logic [15:0] capture_value_register;
  logic [15:0] capture_history_buffer;
  logic [7:0] channel_event_status;
  logic [7:0] channel_control;
  logic [7:0] irq_mask;
  logic [7:0] read_armed;
  cbs_meas_e meas_state;
  logic evt_q;
  logic ext_q;
  logic measure_mode_select;
  logic [2:0] clock_source_select;
  logic ext_clock_edge_select;
  logic count_tick;
  logic capture_evt;
  logic wrap_evt;
  logic match_evt;
  logic too_long_evt;
  logic first_edge;
  logic counter_written;
  logic limit_written;

  assign measure_mode_select = channel_control[CTL_MODE];
  assign clock_source_select = channel_control[CTL_CLK_LSB +: 3];
  assign ext_clock_edge_select = channel_event_status[BIT_EDGE_SEL];

  // Both detectors reset low. A pin that idles high then shows one false rising
  // edge on the first clock, which is harmless because the run bit is still clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_q <= 1'b0;
    else
      evt_q <= event_input_pin;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_q <= 1'b0;
    else
      ext_q <= ext_count_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and event sources.

  function automatic logic edge_seen(input logic cur, input logic prev, input logic rise);
    edge_seen = rise ? (cur && !prev) : (!cur && prev);
  endfunction : edge_seen

  // Internal ticks arrive as one-cycle pulses from the shared prescaler; index
  // seven is the external clock, whose edge is found here.
  always_comb
  begin
    if (clock_source_select == CLK_EXTERNAL)
      count_tick = edge_seen(ext_count_clock, ext_q, ext_clock_edge_select);
    else
      count_tick = prescale_tick[clock_source_select];
  end

  logic pin_edge;
  assign pin_edge = edge_seen(event_input_pin, evt_q, channel_control[CTL_CAP_EDGE]);
  // The first edge of a period only clears the counter; the second one captures.
  assign first_edge = pin_edge && measure_mode_select && meas_state == CBS_WAIT_FIRST;
  assign capture_evt = pin_edge && channel_control[CTL_RUN] && !first_edge;
  assign counter_written = wr_hit(wr_full, req.addr, REG_COUNTER) && !measure_mode_select;
  // A narrow write is ignored whole; half a limit would match at random.
  assign limit_written = wr_hit(wr_full, req.addr, REG_LIMIT);
  // The wrap is taken on the tick that moves all ones to zero, never on a
  // software write of zero.
  assign wrap_evt = channel_control[CTL_RUN] && count_tick && !first_edge
                    && free_running_counter == COUNT_MAX;
  // Compare is skipped in the cycle the limit is written, so a half-updated value never matches.
  assign match_evt = !measure_mode_select && channel_control[CTL_RUN] && !limit_written
                     && free_running_counter == upper_limit_compare;
  // The comparison uses the counter word that is being captured in this very
  // edge, which is the new capture value.
  assign too_long_evt = measure_mode_select && capture_evt
                        && free_running_counter > upper_limit_compare;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and measurement sequence.

  // The sequence restarts whenever the mode or the run bit drops, so a stale
  // first edge never turns a new period into a capture.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      meas_state <= CBS_WAIT_FIRST;
    else if (!measure_mode_select || !channel_control[CTL_RUN])
      meas_state <= CBS_WAIT_FIRST;
    else
    begin
      case (meas_state)
        CBS_WAIT_FIRST: if (pin_edge) meas_state <= CBS_MEASURE;
        CBS_MEASURE: meas_state <= CBS_MEASURE;
        default: meas_state <= CBS_WAIT_FIRST;
      endcase
    end
  end

  // Timer mode with the run bit clear holds the counter at zero; in measurement
  // mode software cannot write it, so a running period is never disturbed.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      free_running_counter <= COUNT_RESET;
    else if (counter_written)
      free_running_counter <= req.wdata[15:0];
    else if (!channel_control[CTL_RUN] && !measure_mode_select)
      free_running_counter <= COUNT_RESET;
    else if (first_edge)
      free_running_counter <= COUNT_RESET;
    else if (channel_control[CTL_RUN] && count_tick)
      free_running_counter <= free_running_counter + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_value_register <= COUNT_RESET;
    else if (capture_evt)
      capture_value_register <= free_running_counter;
  end

  // The buffer takes the old capture word at the same edge, so software can
  // read two consecutive periods without racing the next capture.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_history_buffer <= HISTORY_RESET;
    else if (capture_evt)
      capture_history_buffer <= capture_value_register;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      upper_limit_compare <= LIMIT_RESET;
    else if (limit_written)
      upper_limit_compare <= req.wdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_control <= CONTROL_RESET;
    else if (wr_hit(wr_full, req.addr, REG_CONTROL))
      channel_control <= req.wdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= STATUS_RESET;
    else if (wr_hit(wr_full, req.addr, REG_IRQ_MASK))
      irq_mask <= req.wdata[7:0] & FLAG_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: read-as-one then write-zero clears; a new event wins.

  logic [7:0] events;
  logic [7:0] clear_req;
  logic status_wr;

  assign events = {wrap_evt, too_long_evt, match_evt, 1'b0, capture_evt, 3'b000};
  assign status_wr = wr_hit(wr_full, req.addr, REG_STATUS);
  assign clear_req = status_wr ? (read_armed & ~req.wdata[7:0] & FLAG_MASK) : 8'h00;

  // The arm latch records the flags standing in the answer cycle, one cycle after the read data are taken. Any status
  // write disarms them all, so each clear needs a fresh read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_armed <= STATUS_RESET;
    else if (rd_en && hit(req.addr, REG_STATUS))
      read_armed <= channel_event_status & FLAG_MASK;
    else if (status_wr)
      read_armed <= STATUS_RESET;
  end

  // Set wins over clear: an event in the clearing cycle leaves its flag standing,
  // but a flag set during the wait state of a status read is armed unread, so a zero write then clears it.
  // The edge select is a setting, not an event: it keeps its value between
  // status writes while the event bits obey the read-then-clear sequence.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_event_status <= STATUS_RESET;
    else
    begin
      channel_event_status <= ((channel_event_status & ~clear_req) | events) & FLAG_MASK;
      if (status_wr)
        channel_event_status[BIT_EDGE_SEL] <= req.wdata[BIT_EDGE_SEL];
      else
        channel_event_status[BIT_EDGE_SEL] <= channel_event_status[BIT_EDGE_SEL];
    end
  end

  // Registered so the pin is glitch free; it follows the flags one cycle late.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(channel_event_status & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, so read data are registered.
  //
  // Register map, one aligned word each:
  //   0x00 counter, 0x04 limit/compare, 0x08 capture, 0x0C history,
  //   0x10 status, 0x14 control, 0x18 interrupt mask.
  // Sixteen-bit registers sit in bits 15:0 and eight-bit ones in bits 7:0;
  // the upper bits always read as zero.
  // Any other offset answers with an error, and a read also with a fixed marker word, so a
  // stray pointer in software is easy to spot on a trace.

  cbs_rsp_s next_rsp;

  always_comb
  begin
    next_rsp = '{rdata: 32'h0000_0000, err: 1'b0};
    case (req.addr)
      REG_COUNTER: next_rsp.rdata = {16'h0000, free_running_counter};
      REG_LIMIT: next_rsp.rdata = {16'h0000, upper_limit_compare};
      REG_CAPTURE: next_rsp.rdata = {16'h0000, capture_value_register};
      REG_HISTORY: next_rsp.rdata = {16'h0000, capture_history_buffer};
      REG_STATUS: next_rsp.rdata = {24'h00_0000, channel_event_status};
      REG_CONTROL: next_rsp.rdata = {24'h00_0000, channel_control};
      REG_IRQ_MASK: next_rsp.rdata = {24'h00_0000, irq_mask};
      default: next_rsp = '{rdata: ERR_DATA, err: 1'b1};
    endcase
    if (req.write && !full_word)
      next_rsp.err = 1'b1;
  end

  // The answer comes one cycle into the access phase and lasts one cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // Read data are driven only with pready, so a stale word never lingers on the bus.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && penable && !pready && !req.write)
      prdata <= next_rsp.rdata;
    else
      prdata <= 32'h0000_0000;
  end

  // Errors flag unmapped offsets and narrow writes; both leave every register
  // untouched.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (psel && penable && !pready)
      pslverr <= next_rsp.err;
    else
      pslverr <= 1'b0;
  end

endmodule : cbs_top
